//--- rtl/mmr_router.sv
`timescale 1ns/1ps
// Summary of operation
// - instruction tight memory is one 64-bit interface based at address zero
// - data tight memory is two interleaved 32-bit banks based at 0x2000_0000
// - after reset data tight memory enabled, instruction tight memory disabled
// - nonvolatile bits [8:7] size both tight memories, remaining SRAM follows
// - disabled or out-of-size tight memory accesses go to flash or ROM
// - SRAM accesses past the implemented size never raise an error
// - enabled instruction tight memory overrides ROM or flash at address zero
// - ROM always at 0x0080_0000, aliased at zero when boot bit selects it
// - system SRAM decoded at 0x2040_0000, 384 or 256 KB by variant
// - four SRAM ports: two for the processor, two shared by matrix masters
// - each request carries one of four priority levels to the SRAM
// - SRAM conflicts: more urgent first, the other one cycle later at most
// - 1 KB backup SRAM at 0x4007_4000 takes full words only
// - internal flash decoded from 0x0040_0000
// - window at 0x8000_0000 forwarded to the serial flash interface
// - processor peripheral accesses use peripheral or main port per control bit
// - the peripheral port never carries instruction fetches
// - matrix slave port reaches instruction and both data tight banks
// - main processor port reaches the matrix and two SRAM ports
// - flash sectors are 128 KB; first one split into 8, 8 and 112 KB
// - boot bit 0 maps ROM at zero, 1 maps flash
module mmr_router (
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic [8:0]        i_nvm_bits,
    input  wire logic              i_small_variant,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [7:0]        i_awaddr,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    output logic [1:0]             o_bresp,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    input  wire logic [7:0]        i_araddr,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    input  wire logic [1:0]        i_req_valid,
    output logic [1:0]             o_req_ready,
    input  wire logic [1:0][31:0]  i_req_addr,
    input  wire logic [1:0]        i_req_fetch,
    input  wire logic [1:0][1:0]   i_req_size,
    input  wire logic [1:0][1:0]   i_req_prio,
    output logic [1:0]             o_rt_valid,
    output logic [1:0][3:0]        o_rt_target,
    output logic [1:0][31:0]       o_rt_offset,
    output logic [1:0]             o_rt_error,
    output logic [1:0]             o_rt_fetch,
    output logic [1:0][1:0]        o_rt_prio,
    output logic [1:0][1:0]        o_rt_sram_port,
    output logic [1:0][1:0]        o_rt_bank,
    output logic [1:0][4:0]        o_rt_sector
);

    function automatic logic [4:0] route_decode(
        input logic [31:0] a,
        input logic        cpu,
        input logic        fetch,
        input logic [1:0]  sz,
        input logic [3:0]  cf,
        input logic [31:0] tl,
        input logic [31:0] sl
    );
        logic [3:0] bt;
        logic [3:0] t;
        logic       e;
        bt = cf[0] ? mmr_pkg::TGT_FLASH : mmr_pkg::TGT_ROM;
        t  = mmr_pkg::TGT_NONE;
        e  = 1'b0;
        if (a < mmr_pkg::ALIAS_END) begin
            if (cf[3] && a < tl) begin
                t = mmr_pkg::TGT_INSTRUCTION_TIGHT_MEMORY;
            end else begin
                t = bt;
            end
        end else if (a < mmr_pkg::ROM_BASE) begin
            if (a - mmr_pkg::FLASH_BASE < mmr_pkg::FLASH_BYTES) begin
                t = mmr_pkg::TGT_FLASH;
            end
        end else if (a < mmr_pkg::ROM_END) begin
            t = mmr_pkg::TGT_ROM;
        end else if (a >= mmr_pkg::DATA_TIGHT_MEMORY_BASE && a < mmr_pkg::SRAM_BASE) begin
            if (cf[2] && a - mmr_pkg::DATA_TIGHT_MEMORY_BASE < tl) begin
                t = a[2] ? mmr_pkg::TGT_DTCM1 : mmr_pkg::TGT_DTCM0;
            end else begin
                t = bt;
            end
        end else if (a >= mmr_pkg::SRAM_BASE && a < mmr_pkg::PERIPH_BASE) begin
            // past the limit falls through to flash or ROM, never an error
            t = (a - mmr_pkg::SRAM_BASE < sl) ? mmr_pkg::TGT_SRAM : bt;
        end else if (a >= mmr_pkg::BKUP_BASE &&
                     a - mmr_pkg::BKUP_BASE < mmr_pkg::BKUP_BYTES) begin
            t = mmr_pkg::TGT_BKUP;
            e = (sz != mmr_pkg::SIZE_WORD);
        end else if (a >= mmr_pkg::PERIPH_BASE && a < mmr_pkg::PERIPH_END) begin
            if (!cpu) begin
                t = mmr_pkg::TGT_MATRIX;
            end else if (cf[1] && !fetch) begin
                t = mmr_pkg::TGT_PPORT;
            end else begin
                t = mmr_pkg::TGT_MAIN;
            end
        end else if (a >= mmr_pkg::QSPI_BASE && a < mmr_pkg::QSPI_END) begin
            t = mmr_pkg::TGT_QSPI;
        end
        if (t == mmr_pkg::TGT_NONE) begin
            e = 1'b1;
        end
        return {e, t};
    endfunction

    function automatic logic [31:0] route_base(
        input logic [3:0]  t,
        input logic [31:0] a
    );
        logic [31:0] b;
        b = 32'h0000_0000;
        case (t)
            mmr_pkg::TGT_DTCM0,
            mmr_pkg::TGT_DTCM1: b = mmr_pkg::DATA_TIGHT_MEMORY_BASE;
            mmr_pkg::TGT_SRAM:  b = mmr_pkg::SRAM_BASE;
            mmr_pkg::TGT_BKUP:  b = mmr_pkg::BKUP_BASE;
            mmr_pkg::TGT_QSPI:  b = mmr_pkg::QSPI_BASE;
            mmr_pkg::TGT_ROM: begin
                if (a >= mmr_pkg::ROM_BASE && a < mmr_pkg::ROM_END) begin
                    b = mmr_pkg::ROM_BASE;
                end
            end
            mmr_pkg::TGT_FLASH: begin
                if (a >= mmr_pkg::FLASH_BASE && a < mmr_pkg::ROM_BASE) begin
                    b = mmr_pkg::FLASH_BASE;
                end
            end
            default: b = 32'h0000_0000;
        endcase
        return b;
    endfunction

    function automatic logic [4:0] flash_sector(input logic [31:0] off);
        logic [4:0] s;
        if (off < mmr_pkg::SEC_SMALL0) begin
            s = 5'h00;
        end else if (off < mmr_pkg::SEC_SMALL1) begin
            s = 5'h01;
        end else if (off < mmr_pkg::SEC_FIRST) begin
            s = 5'h02;
        end else begin
            s = off[21:17] + mmr_pkg::SEC_SKIP;
        end
        return s;
    endfunction

    function automatic logic reg_mapped(input logic [7:0] ad);
        return ad == mmr_pkg::REG_CTRL || ad == mmr_pkg::REG_STATUS ||
               ad == mmr_pkg::REG_CONFLICTS || ad == mmr_pkg::REG_TCM_LIM ||
               ad == mmr_pkg::REG_SRAM_LIM;
    endfunction

    // configuration captured once after reset release
    logic [1:0]  tcm_code;
    logic        boot_flash;
    logic        small_var;
    logic        cfg_done;
    logic [2:0]  ctrl;
    logic [15:0] conflicts;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tcm_code   <= 2'h0;
            boot_flash <= 1'b0;
            small_var  <= 1'b0;
            cfg_done   <= 1'b0;
        end else if (!cfg_done) begin
            tcm_code   <= i_nvm_bits[mmr_pkg::NVM_TCM_HI:mmr_pkg::NVM_TCM_LO];
            boot_flash <= i_nvm_bits[mmr_pkg::NVM_BOOT];
            small_var  <= i_small_variant;
            cfg_done   <= 1'b1;
        end
    end

    wire [31:0] tcm_lim  = (tcm_code == 2'h0) ? 32'h0000_0000 :
                           mmr_pkg::TCM_UNIT << (tcm_code - 2'h1);
    wire [31:0] sram_tot = small_var ? mmr_pkg::SRAM_SMALL : mmr_pkg::SRAM_LARGE;
    wire [31:0] sram_lim = sram_tot - {tcm_lim[30:0], 1'b0};
    wire [3:0]  cfg_vec  = {ctrl[mmr_pkg::CTRL_INSTRUCTION_TIGHT_MEMORY], ctrl[mmr_pkg::CTRL_DATA_TIGHT_MEMORY],
                            ctrl[mmr_pkg::CTRL_PPORT], boot_flash};

    // request path; a held request has precedence so it waits one cycle only
    logic [1:0]        hold_v;
    logic [1:0][31:0]  hold_addr;
    logic [1:0]        hold_fetch;
    logic [1:0][1:0]   hold_size;
    logic [1:0][1:0]   hold_prio;
    logic [1:0]        eff_valid;
    logic [1:0][31:0]  eff_addr;
    logic [1:0]        eff_fetch;
    logic [1:0][1:0]   eff_size;
    logic [1:0][1:0]   eff_prio;
    logic [1:0][4:0]   dec;
    logic [1:0]        issue;
    logic [1:0]        lose;
    logic [1:0]        next_hold_v;

    wire both_sram = eff_valid[0] && eff_valid[1] &&
                     dec[0][3:0] == mmr_pkg::TGT_SRAM &&
                     dec[1][3:0] == mmr_pkg::TGT_SRAM;
    wire conflict  = both_sram && eff_addr[0][3:2] == eff_addr[1][3:2];
    wire win_one   = hold_v[1] ? 1'b1 :
                     hold_v[0] ? 1'b0 :
                     (eff_prio[1] > eff_prio[0]);

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            assign eff_valid[p] = hold_v[p] | (i_req_valid[p] & o_req_ready[p]);
            assign eff_addr[p]  = hold_v[p] ? hold_addr[p]  : i_req_addr[p];
            assign eff_fetch[p] = hold_v[p] ? hold_fetch[p] : i_req_fetch[p];
            assign eff_size[p]  = hold_v[p] ? hold_size[p]  : i_req_size[p];
            assign eff_prio[p]  = hold_v[p] ? hold_prio[p]  : i_req_prio[p];
            assign dec[p] = route_decode(eff_addr[p], p == 0, eff_fetch[p],
                                         eff_size[p], cfg_vec, tcm_lim,
                                         sram_lim);
            assign lose[p]        = conflict && (win_one != (p == 1));
            assign issue[p]       = eff_valid[p] & ~lose[p];
            assign next_hold_v[p] = lose[p];

            wire [31:0] off = eff_addr[p] - route_base(dec[p][3:0], eff_addr[p]);
            wire [1:0]  bank = (dec[p][3:0] == mmr_pkg::TGT_SRAM) ?
                               eff_addr[p][3:2] : {1'b0, eff_addr[p][2]};

            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    hold_v[p]     <= 1'b0;
                    hold_addr[p]  <= 32'h0000_0000;
                    hold_fetch[p] <= 1'b0;
                    hold_size[p]  <= 2'h0;
                    hold_prio[p]  <= 2'h0;
                    o_req_ready[p] <= 1'b0;
                end else begin
                    hold_v[p]     <= next_hold_v[p];
                    hold_addr[p]  <= eff_addr[p];
                    hold_fetch[p] <= eff_fetch[p];
                    hold_size[p]  <= eff_size[p];
                    hold_prio[p]  <= eff_prio[p];
                    o_req_ready[p] <= cfg_done & ~next_hold_v[p];
                end
            end

            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_rt_valid[p]     <= 1'b0;
                    o_rt_target[p]    <= mmr_pkg::TGT_NONE;
                    o_rt_offset[p]    <= 32'h0000_0000;
                    o_rt_error[p]     <= 1'b0;
                    o_rt_fetch[p]     <= 1'b0;
                    o_rt_prio[p]      <= 2'h0;
                    o_rt_sram_port[p] <= 2'h0;
                    o_rt_bank[p]      <= 2'h0;
                    o_rt_sector[p]    <= 5'h00;
                end else begin
                    o_rt_valid[p]     <= issue[p];
                    o_rt_target[p]    <= dec[p][3:0];
                    o_rt_offset[p]    <= off;
                    o_rt_error[p]     <= dec[p][4];
                    o_rt_fetch[p]     <= eff_fetch[p];
                    o_rt_prio[p]      <= eff_prio[p];
                    o_rt_sram_port[p] <= {p == 1, eff_addr[p][3]};
                    o_rt_bank[p]      <= bank;
                    o_rt_sector[p]    <= flash_sector(off);
                end
            end
        end
    endgenerate

    // register slave
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    wire aw_fire  = i_awvalid & o_awready;
    wire w_fire   = i_wvalid & o_wready;
    wire ar_fire  = i_arvalid & o_arready;
    wire do_write = aw_got & w_got & ~o_bvalid;
    wire next_aw_got = aw_fire | (aw_got & ~do_write);
    wire next_w_got  = w_fire | (w_got & ~do_write);
    wire next_rvalid = ar_fire | (o_rvalid & ~i_rready);
    wire wr_ctrl  = do_write && aw_addr_q == mmr_pkg::REG_CTRL && w_strb_q[0];
    wire clr_cnt  = do_write && aw_addr_q == mmr_pkg::REG_CONFLICTS;
    wire [31:0] status_word = {25'h0, hold_v, cfg_done, small_var,
                               boot_flash, tcm_code};
    wire [31:0] rd_word =
        (i_araddr == mmr_pkg::REG_CTRL)      ? {29'h0, ctrl} :
        (i_araddr == mmr_pkg::REG_STATUS)    ? status_word :
        (i_araddr == mmr_pkg::REG_CONFLICTS) ? {16'h0, conflicts} :
        (i_araddr == mmr_pkg::REG_TCM_LIM)   ? tcm_lim :
        (i_araddr == mmr_pkg::REG_SRAM_LIM)  ? sram_lim : 32'h0000_0000;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= mmr_pkg::RESP_OKAY;
        end else begin
            aw_got    <= next_aw_got;
            w_got     <= next_w_got;
            o_awready <= ~next_aw_got;
            o_wready  <= ~next_w_got;
            if (aw_fire) begin
                aw_addr_q <= i_awaddr;
            end
            if (w_fire) begin
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end
            if (do_write) begin
                o_bvalid <= 1'b1;
                o_bresp  <= reg_mapped(aw_addr_q) ? mmr_pkg::RESP_OKAY :
                                                    mmr_pkg::RESP_SLVERR;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= mmr_pkg::RESP_OKAY;
        end else begin
            o_arready <= ~next_rvalid;
            o_rvalid  <= next_rvalid;
            if (ar_fire) begin
                o_rdata <= rd_word;
                o_rresp <= reg_mapped(i_araddr) ? mmr_pkg::RESP_OKAY :
                                                  mmr_pkg::RESP_SLVERR;
            end
        end
    end

    // tight memory enables and peripheral port select
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl <= mmr_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= w_data_q[2:0];
        end
    end

    // a conflict in the clearing cycle still counts
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            conflicts <= 16'h0000;
        end else if (conflict) begin
            conflicts <= clr_cnt ? 16'h0001 : conflicts + 16'h0001;
        end else if (clr_cnt) begin
            conflicts <= 16'h0000;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    property p_cfg_hold;
        cfg_done && $past(cfg_done) |-> $stable(tcm_code) && $stable(boot_flash);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("address map changed after reset release");

    property p_loser_next;
        conflict |=> (hold_v[0] ^ hold_v[1]) ##1 (hold_v == 2'b00 || conflict);
    endproperty
    a_loser_next: assert property (p_loser_next)
        else $error("conflict loser not completed next cycle");

    property p_hold_once;
        hold_v[1] |=> !hold_v[1] && o_req_ready[1];
    endproperty
    a_hold_once: assert property (p_hold_once)
        else $error("held request stayed held two cycles");

    property p_bkup_word;
        issue[0] && dec[0][3:0] == mmr_pkg::TGT_BKUP &&
        eff_size[0] != mmr_pkg::SIZE_WORD |=> o_rt_valid[0] && o_rt_error[0];
    endproperty
    a_bkup_word: assert property (p_bkup_word)
        else $error("narrow backup SRAM access not refused");

    property p_sram_noerr;
        issue[1] && eff_addr[1] >= mmr_pkg::SRAM_BASE &&
        eff_addr[1] < mmr_pkg::PERIPH_BASE |=> !o_rt_error[1];
    endproperty
    a_sram_noerr: assert property (p_sram_noerr)
        else $error("SRAM range access raised an error");

    property p_instruction_tight_memory_zero;
        issue[0] && ctrl[mmr_pkg::CTRL_INSTRUCTION_TIGHT_MEMORY] && eff_addr[0] < tcm_lim |=>
        o_rt_target[0] == mmr_pkg::TGT_INSTRUCTION_TIGHT_MEMORY;
    endproperty
    a_instruction_tight_memory_zero: assert property (p_instruction_tight_memory_zero)
        else $error("enabled instruction tight memory not selected");

    property p_boot_rom;
        issue[0] && !boot_flash && eff_addr[0] < mmr_pkg::ALIAS_END &&
        !ctrl[mmr_pkg::CTRL_INSTRUCTION_TIGHT_MEMORY] |=> o_rt_target[0] == mmr_pkg::TGT_ROM &&
        o_rt_offset[0] == $past(eff_addr[0]);
    endproperty
    a_boot_rom: assert property (p_boot_rom)
        else $error("boot alias did not select ROM");

    property p_no_fetch_pport;
        o_rt_valid[0] && o_rt_target[0] == mmr_pkg::TGT_PPORT |->
        !o_rt_fetch[0] && $past(ctrl[mmr_pkg::CTRL_PPORT]);
    endproperty
    a_no_fetch_pport: assert property (p_no_fetch_pport)
        else $error("fetch or unselected access on peripheral port");

    property p_prio_carry;
        issue[1] |=> o_rt_prio[1] == $past(eff_prio[1]);
    endproperty
    a_prio_carry: assert property (p_prio_carry)
        else $error("priority level not carried");

endmodule

//--- rtl/mmr_pkg.sv
package mmr_pkg;

    // address map
    localparam logic [31:0] INSTRUCTION_TIGHT_MEMORY_BASE    = 32'h0000_0000;
    localparam logic [31:0] ALIAS_END    = 32'h0040_0000;
    localparam logic [31:0] FLASH_BASE   = 32'h0040_0000;
    localparam logic [31:0] ROM_BASE     = 32'h0080_0000;
    localparam logic [31:0] ROM_END      = 32'h00c0_0000;
    localparam logic [31:0] DATA_TIGHT_MEMORY_BASE    = 32'h2000_0000;
    localparam logic [31:0] SRAM_BASE    = 32'h2040_0000;
    localparam logic [31:0] PERIPH_BASE  = 32'h4000_0000;
    localparam logic [31:0] PERIPH_END   = 32'h6000_0000;
    localparam logic [31:0] BKUP_BASE    = 32'h4007_4000;
    localparam logic [31:0] BKUP_BYTES   = 32'h0000_0400;
    localparam logic [31:0] QSPI_BASE    = 32'h8000_0000;
    localparam logic [31:0] QSPI_END     = 32'ha000_0000;

    // sizes
    localparam logic [31:0] TCM_UNIT     = 32'h0000_8000;
    localparam logic [31:0] SRAM_LARGE   = 32'h0006_0000;
    localparam logic [31:0] SRAM_SMALL   = 32'h0004_0000;
    localparam logic [31:0] FLASH_BYTES  = 32'h0020_0000;
    localparam logic [31:0] SEC_SMALL0   = 32'h0000_2000;
    localparam logic [31:0] SEC_SMALL1   = 32'h0000_4000;
    localparam logic [31:0] SEC_FIRST    = 32'h0002_0000;
    localparam logic [4:0]  SEC_SKIP     = 5'h02;

    // nonvolatile bit positions
    localparam int NVM_BOOT   = 1;
    localparam int NVM_TCM_LO = 7;
    localparam int NVM_TCM_HI = 8;

    // register offsets and fields
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_CONFLICTS = 8'h08;
    localparam logic [7:0] REG_TCM_LIM   = 8'h0c;
    localparam logic [7:0] REG_SRAM_LIM  = 8'h10;
    localparam int         CTRL_INSTRUCTION_TIGHT_MEMORY     = 0;
    localparam int         CTRL_DATA_TIGHT_MEMORY     = 1;
    localparam int         CTRL_PPORT    = 2;
    localparam logic [2:0] CTRL_RESET    = 3'h6;

    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    localparam logic [1:0] SIZE_WORD     = 2'h2;

    typedef enum logic [3:0] {
        TGT_NONE   = 4'h0,
        TGT_INSTRUCTION_TIGHT_MEMORY   = 4'h1,
        TGT_DTCM0  = 4'h2,
        TGT_DTCM1  = 4'h3,
        TGT_SRAM   = 4'h4,
        TGT_ROM    = 4'h5,
        TGT_FLASH  = 4'h6,
        TGT_QSPI   = 4'h7,
        TGT_BKUP   = 4'h8,
        TGT_PPORT  = 4'h9,
        TGT_MAIN   = 4'ha,
        TGT_MATRIX = 4'hb
    } mmr_target_t;

endpackage

//--- test/mmr_req_src.sv
`timescale 1ns/1ps
module mmr_req_src (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_go,
    input  wire logic [31:0] i_addr,
    input  wire logic        i_fetch,
    input  wire logic [1:0]  i_size,
    input  wire logic [1:0]  i_prio,
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic [31:0]      o_addr,
    output logic             o_fetch,
    output logic [1:0]       o_size,
    output logic [1:0]       o_prio
);
    // address and priority are scrambled once taken so a stale copy is never mistaken
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_valid <= 1'b0;
        end else if (i_go) begin
            o_valid <= 1'b1;
            o_addr  <= i_addr;
            o_fetch <= i_fetch;
            o_size  <= i_size;
            o_prio  <= i_prio;
        end else if (o_valid && i_ready) begin
            o_valid <= 1'b0;
            o_addr  <= ~o_addr;
            o_prio  <= ~o_prio;
        end
    end
endmodule

//--- test/mmr_router_tb_top.sv
`timescale 1ns/1ps
module mmr_router_tb_top;
    logic i_clk, i_resetn, i_small_variant, i_awvalid, i_wvalid, i_bready;
    logic i_arvalid, i_rready, o_awready, o_wready, o_bvalid, o_arready;
    logic o_rvalid;
    logic [8:0] i_nvm_bits;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, i_req_valid, o_req_ready, i_req_fetch;
    logic [1:0] o_rt_valid, o_rt_error, o_rt_fetch, go, gf;
    logic [1:0][31:0] i_req_addr, o_rt_offset, ga, co;
    logic [1:0][1:0] i_req_size, i_req_prio, o_rt_prio, o_rt_sram_port;
    logic [1:0][1:0] o_rt_bank, gs, gp, cp, cs, cb;
    logic [1:0][3:0] o_rt_target, ct;
    logic [1:0][4:0] o_rt_sector, cx;
    logic [1:0] ce;
    logic [1:0] rsz;
    logic rfe;
    int cnt [2];
    int ck [2];
    int cyc, err_count, comparisons;
    mmr_router i_mmr_router (.i_clk, .i_resetn, .i_nvm_bits, .i_small_variant,
        .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
        .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
        .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_req_valid,
        .o_req_ready, .i_req_addr, .i_req_fetch, .i_req_size, .i_req_prio,
        .o_rt_valid, .o_rt_target, .o_rt_offset, .o_rt_error, .o_rt_fetch,
        .o_rt_prio, .o_rt_sram_port, .o_rt_bank, .o_rt_sector);
    for (genvar k = 0; k < 2; k++) begin : g_src
        mmr_req_src i_mmr_req_src (.i_clk, .i_resetn, .i_go(go[k]),
            .i_addr(ga[k]), .i_fetch(gf[k]), .i_size(gs[k]), .i_prio(gp[k]),
            .i_ready(o_req_ready[k]), .o_valid(i_req_valid[k]),
            .o_addr(i_req_addr[k]), .o_fetch(i_req_fetch[k]),
            .o_size(i_req_size[k]), .o_prio(i_req_prio[k]));
    end
    initial begin
        i_clk = 0;
        forever #2.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            err_count++;
            tally_and_finish;
        end
        for (int k = 0; k < 2; k++)
            if (o_rt_valid[k] === 1'b1) begin
                ct[k] <= o_rt_target[k];
                co[k] <= o_rt_offset[k];
                ce[k] <= o_rt_error[k];
                cp[k] <= o_rt_prio[k];
                cs[k] <= o_rt_sram_port[k];
                cb[k] <= o_rt_bank[k];
                cx[k] <= o_rt_sector[k];
                cnt[k] <= cnt[k] + 1;
                ck[k] <= cyc;
            end
    end
    task chk(logic [31:0] g, logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("Error %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task tally_and_finish;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task wr(logic [7:0] a, logic [31:0] d);
        int n;
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge i_clk);
            if (o_awready === 1'b1) i_awvalid <= 0;
            if (o_wready === 1'b1) i_wvalid <= 0;
            if (o_bvalid === 1'b1) break;
        end
        i_bready <= 0;
        chk(o_bresp, mmr_pkg::RESP_OKAY);
    endtask
    task rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        int n;
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge i_clk);
            if (o_arready === 1'b1) i_arvalid <= 0;
            if (o_rvalid === 1'b1) break;
        end
        i_rready <= 0;
        chk(o_rdata, ed);
        chk(o_rresp, er);
    endtask
    task put(int p, logic [31:0] a, logic [1:0] pr);
        ga[p] <= a;
        gf[p] <= rfe;
        gs[p] <= rsz;
        gp[p] <= pr;
    endtask
    task fire(logic [1:0] m);
        int c0 [2];
        int n;
        c0 = cnt;
        go <= m;
        @(posedge i_clk);
        go <= 2'b00;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if ((!m[0] || cnt[0] != c0[0]) && (!m[1] || cnt[1] != c0[1]))
                break;
        end
    endtask
    task rt(int p, logic [31:0] a, logic [3:0] t, logic [31:0] o, logic e);
        put(p, a, 2'h0);
        fire(p ? 2'b10 : 2'b01);
        chk(ct[p], t);
        chk(co[p], o);
        chk(ce[p], e);
    endtask
    initial begin
        {i_resetn, i_small_variant, i_awvalid, i_wvalid, i_bready} = 0;
        {i_arvalid, i_rready, go, i_awaddr, i_araddr, i_wdata} = 0;
        {ga, gf, gs, gp, cyc, err_count, comparisons, rfe} = 0;
        i_wstrb = 4'hf;
        rsz = 2'h2;
        i_nvm_bits = 9'h080;
        repeat (10) @(posedge i_clk);
        i_resetn <= 1;
        repeat (3) @(posedge i_clk);
        rd(8'h00, 32'h6, mmr_pkg::RESP_OKAY);
        rd(8'h40, 32'h0, mmr_pkg::RESP_SLVERR);
        rt(0, 32'h100, mmr_pkg::TGT_ROM, 32'h100, 0);
        rt(0, 32'h2000_0000, mmr_pkg::TGT_DTCM0, 32'h0, 0);
        rt(0, 32'h2000_0004, mmr_pkg::TGT_DTCM1, 32'h4, 0);
        wr(8'h00, 32'h7);
        rt(0, 32'h100, mmr_pkg::TGT_INSTRUCTION_TIGHT_MEMORY, 32'h100, 0);
        rt(0, 32'h8000, mmr_pkg::TGT_ROM, 32'h8000, 0);
        rt(0, 32'h80_0010, mmr_pkg::TGT_ROM, 32'h10, 0);
        rt(0, 32'h40_2000, mmr_pkg::TGT_FLASH, 32'h2000, 0);
        chk(cx[0], 5'h01);
        rt(0, 32'h42_0000, mmr_pkg::TGT_FLASH, 32'h2_0000, 0);
        chk(cx[0], 5'h03);
        rt(0, 32'h4007_4000, mmr_pkg::TGT_BKUP, 32'h0, 0);
        rt(0, 32'h8000_0000, mmr_pkg::TGT_QSPI, 32'h0, 0);
        rt(0, 32'h2040_0008, mmr_pkg::TGT_SRAM, 32'h8, 0);
        chk(cs[0], 2'h1);
        chk(cb[0], 2'h2);
        rt(0, 32'h2045_0000, mmr_pkg::TGT_ROM, 32'h2045_0000, 0);
        rt(0, 32'h4000_1000, mmr_pkg::TGT_PPORT, 32'h4000_1000, 0);
        rt(1, 32'h2000_0004, mmr_pkg::TGT_DTCM1, 32'h4, 0);
        rt(1, 32'h4000_1000, mmr_pkg::TGT_MATRIX, 32'h4000_1000, 0);
        rfe = 1;
        rt(0, 32'h4000_1000, mmr_pkg::TGT_MAIN, 32'h4000_1000, 0);
        rfe = 0;
        wr(8'h00, 32'h3);
        rt(0, 32'h4000_1000, mmr_pkg::TGT_MAIN, 32'h4000_1000, 0);
        rsz = 2'h0;
        put(0, 32'h4007_4004, 2'h0);
        fire(2'b01);
        chk(ce[0], 1'b1);
        rsz = 2'h2;
        put(0, 32'h2040_0010, 2'h0);
        put(1, 32'h2040_0030, 2'h3);
        fire(2'b11);
        chk(ck[0] - ck[1], 1);
        chk(cp[1], 2'h3);
        chk(cp[0], 2'h0);
        chk(cs[1], 2'h2);
        put(0, 32'h2040_0014, 2'h2);
        put(1, 32'h2040_0034, 2'h2);
        fire(2'b11);
        chk(ck[1] - ck[0], 1);
        i_nvm_bits <= 9'h182;
        rt(0, 32'h2045_0000, mmr_pkg::TGT_ROM, 32'h2045_0000, 0);
        i_resetn <= 0;
        repeat (3) @(posedge i_clk);
        i_nvm_bits <= 9'h102;
        i_small_variant <= 1;
        i_resetn <= 1;
        repeat (3) @(posedge i_clk);
        rt(0, 32'h100, mmr_pkg::TGT_FLASH, 32'h100, 0);
        rt(0, 32'h2041_fffc, mmr_pkg::TGT_SRAM, 32'h1_fffc, 0);
        rt(0, 32'h2042_0000, mmr_pkg::TGT_FLASH, 32'h2042_0000, 0);
        tally_and_finish;
    end
endmodule
